// ---- tb/comm_switch_config_decoder_test.sv ----
// Self-checking bench for the switch configuration decoder
module comm_switch_config_decoder_test
   import csc_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic        clk = 1'b0, arst_n = 1'b0, sw_t = 1'b0, sw_m = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [7:0]  sw_a = 8'h00, adr = 8'h00, rq_id, uid, a;
   logic [3:0]  sel = 4'hf;
   logic [31:0] wdat = 32'h0, rdat, ip, r, e;
   logic        rq_v, rq_ok, cfg_v, auto_s, fix_s, tcp, rtu, en, ipv, ack, t, m;
   integer      seed = 61;
   int          mismatches = 0, compares = 0;
   // Free-running 40 MHz clock
   always #12.5 clk = ~clk;
   csc_decoder #(.SETTLE_CYC(4)) dut_u (.CLK(clk), .ARST_N(arst_n), .SW_IP_TYPE(sw_t),
      .SW_LINK_MODE(sw_m), .SW_ADDR(sw_a), .REQ_VALID(rq_v), .REQ_UNIT_ID(rq_id),
      .REQ_ACCEPT(rq_ok), .CFG_VALID(cfg_v), .AUTO_ASSIGNED_IP_SELECT(auto_s),
      .FIXED_IP_SELECT(fix_s), .LINK_TCP(tcp), .LINK_RTU(rtu), .COMM_ENABLE(en),
      .UNIT_ID(uid), .IP_ADDR(ip), .IP_ADDR_VALID(ipv), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
      .WB_ACK_O(ack));
   csc_master_model mdl_u (.clk(clk), .req_valid(rq_v), .req_unit_id(rq_id));
   task chk(input logic [32:0] got, input logic [32:0] exp);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task stop_test;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : stop_test
   // Classic single cycle; waits for ack, bounded
   task wb(input logic w, input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge clk);
      {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, ad, d, s};
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (ack !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         mismatches++;
         $display("[FAIL] %0t no bus acknowledge", $time);
      end
      r = rdat;
      {cyc, stb} <= 2'b00;
   endtask : wb
   // Expected status word: id, enable, automatic, tcp, latched
   function automatic logic [31:0] exp_st(logic tt, logic mm, logic [7:0] aa);
      logic ok;
      ok = mm ? (aa != 8'hff) : (aa != 8'h00 && aa != 8'hff);
      return {16'h0, aa, 4'h0, ok, mm & tt, mm, 1'b1};
   endfunction : exp_st
   // Watchdog well beyond the expected run
   initial
   begin
      #300000;
      mismatches++;
      stop_test;
   end
   // Corner addresses first, in Ethernet then RTU mode (factory switch setting on the first only), then random ones
   initial
   begin
      for (int i = 0; i < 16; i++)
      begin
         r = $random(seed);
         a = (i < 8) ? ((i % 4 == 0) ? 8'h00 : (i % 4 == 1) ? 8'h01 : (i % 4 == 2) ? 8'hfe : 8'hff)
                     : r[7:0];
         m = (i < 4) ? CSC_DEF_ETH_SW : (i < 8) ? 1'b0 : r[8];
         t = (i == 0) ? CSC_DEF_DYN_SW : r[9];
         @(posedge clk);
         {arst_n, sw_t, sw_m, sw_a} <= {1'b0, t, m, a};
         repeat (6) @(posedge clk);
         arst_n <= 1'b1;
         repeat (20) @(posedge clk);
         @(negedge clk);
         e = exp_st(t, m, a);
         chk({uid, 4'h0, en, auto_s, tcp, cfg_v}, e[15:0]);
         chk({fix_s, rtu}, {m & ~t, ~m});
         if (m & ~t & a != 8'hff)
            chk({ipv, ip}, {1'b1, CSC_IP_DEFAULT[31:8], (a == 8'h00) ? 8'h01 : a});
         if (m & t)
            chk({ipv, ip}, 33'h0);
         wb(1'b0, CSC_REG_STATUS, 32'h0, 4'hf);
         chk(r, e);
         mdl_u.send(a);
         @(negedge clk);
         chk(rq_ok, e[3]);
         mdl_u.send(a + 8'h01);
         @(negedge clk);
         chk(rq_ok, 1'b0);
         mdl_u.idle;
         {sw_m, sw_a} <= {~m, ~a};
         repeat (8) @(posedge clk);
         chk({uid, tcp}, {a, m});
         $display("switch test %0d done", i);
      end
      wb(1'b0, CSC_REG_IP_STORE, 32'h0, 4'hf);
      chk(r, CSC_IP_DEFAULT);
      wb(1'b1, CSC_REG_IP_STORE, 32'h0a0b0cff, 4'h3);
      wb(1'b0, CSC_REG_IP_STORE, 32'h0, 4'hf);
      chk(r, {CSC_IP_DEFAULT[31:16], 16'h0cff});
      wb(1'b0, 8'h10, 32'h0, 4'hf);
      chk(r, 32'h0);
      $display("register test done");
      stop_test;
   end
endmodule : comm_switch_config_decoder_test

// ---- tb/csc_decoder_assertions.sv ----
// Checker of decoded settings and bus timing for the switch decoder
module csc_decoder_assertions
   import csc_pkg::*;
#(
   parameter int SETTLE_CYC = 4
)
(
   // Watched ports
   input wire logic        CLK,
   input wire logic        ARST_N,
   input wire logic        REQ_VALID,
   input wire logic [7:0]  REQ_UNIT_ID,
   input wire logic        REQ_ACCEPT,
   input wire logic        CFG_VALID,
   input wire logic        AUTO_ASSIGNED_IP_SELECT,
   input wire logic        FIXED_IP_SELECT,
   input wire logic        LINK_TCP,
   input wire logic        LINK_RTU,
   input wire logic        COMM_ENABLE,
   input wire logic [7:0]  UNIT_ID,
   input wire logic [31:0] IP_ADDR,
   input wire logic        IP_ADDR_VALID,
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic        WB_ACK_O
);
   // Latch must land a few edges after the two reset flops and settle count
   localparam int LAT_MAX = SETTLE_CYC + 8;
   default clocking @(posedge CLK); endclocking
   default disable iff (!ARST_N);
   // Bus handshake steps
   sequence s_req;
      WB_CYC_I && WB_STB_I && !WB_ACK_O;
   endsequence
   sequence s_ack_once;
      WB_ACK_O ##1 !WB_ACK_O;
   endsequence
   AST_REQ_MATCH: assert property (REQ_ACCEPT == (REQ_VALID && COMM_ENABLE && REQ_UNIT_ID == UNIT_ID))
      else $error("accept does not follow id match");
   AST_RTU_ZERO: assert property (LINK_RTU && UNIT_ID == 8'h00 |-> !COMM_ENABLE)
      else $error("zero address enabled in RTU mode");
   AST_ADDR_OFF: assert property (CFG_VALID && UNIT_ID == 8'hff |-> !COMM_ENABLE)
      else $error("address 255 enabled");
   AST_RTU_VALID: assert property (LINK_RTU && UNIT_ID inside {[1:254]} |-> COMM_ENABLE)
      else $error("valid RTU address not enabled");
   AST_TYPE_IGN: assert property (LINK_RTU |-> !AUTO_ASSIGNED_IP_SELECT && !FIXED_IP_SELECT)
      else $error("address type honoured in RTU mode");
   AST_MODE_ONE: assert property (CFG_VALID |-> LINK_TCP != LINK_RTU)
      else $error("link mode not exclusive");
   AST_HOLD: assert property (CFG_VALID |=> CFG_VALID && $stable(UNIT_ID) && $stable(LINK_TCP))
      else $error("latched settings changed");
   AST_LATCH_TIME: assert property ($rose(ARST_N) |-> ##[1:LAT_MAX] CFG_VALID)
      else $error("switches not latched in time");
   AST_OCTET4: assert property (IP_ADDR_VALID && UNIT_ID != 8'h00 |-> IP_ADDR[7:0] == UNIT_ID)
      else $error("fourth octet not switch address");
   AST_AUTO_IP: assert property (AUTO_ASSIGNED_IP_SELECT |-> IP_ADDR == 32'h0 && !IP_ADDR_VALID)
      else $error("automatic mode built an address");
   AST_WB_ACK: assert property (s_req |=> s_ack_once)
      else $error("ack not one wait state and one cycle");
endmodule : csc_decoder_assertions

bind csc_decoder csc_decoder_assertions #(.SETTLE_CYC(SETTLE_CYC)) chk_u (.CLK(CLK),
   .ARST_N(ARST_N), .REQ_VALID(REQ_VALID), .REQ_UNIT_ID(REQ_UNIT_ID), .REQ_ACCEPT(REQ_ACCEPT),
   .CFG_VALID(CFG_VALID), .AUTO_ASSIGNED_IP_SELECT(AUTO_ASSIGNED_IP_SELECT),
   .FIXED_IP_SELECT(FIXED_IP_SELECT), .LINK_TCP(LINK_TCP), .LINK_RTU(LINK_RTU),
   .COMM_ENABLE(COMM_ENABLE), .UNIT_ID(UNIT_ID), .IP_ADDR(IP_ADDR),
   .IP_ADDR_VALID(IP_ADDR_VALID), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
   .WB_ACK_O(WB_ACK_O));

// ---- tb/csc_master_model.sv ----
// Behavioural bus master presenting addressed unit identifiers
module csc_master_model
(
   // Clock and request
   input  wire logic  clk,
   output logic       req_valid,
   output logic [7:0] req_unit_id
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      req_valid   = 1'b0;
      req_unit_id = 8'h00;
   end
   // One request per call, held until the next call
   task send(input logic [7:0] id);
      @(posedge clk);
      req_valid   <= 1'b1;
      req_unit_id <= id;
   endtask : send
   // Released id shows the inverse so a stale value cannot match
   task idle;
      @(posedge clk);
      req_valid   <= 1'b0;
      req_unit_id <= ~req_unit_id;
   endtask : idle
endmodule : csc_master_model

// ---- verilog/csc_decoder.sv ----
// Communication switch configuration decoder with Wishbone register access
//
// The implementer's own choices: the Wishbone interface to the registers and the address map.

module csc_decoder
   import csc_pkg::*;
#(
   parameter int SETTLE_CYC = CSC_SETTLE_CYC
)
(
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        ARST_N,
   // Configuration switches, high when ON
   input  wire logic        SW_IP_TYPE,
   input  wire logic        SW_LINK_MODE,
   input  wire logic [7:0]  SW_ADDR,
   // Unit identifier check from the frame handler
   input  wire logic        REQ_VALID,
   input  wire logic [7:0]  REQ_UNIT_ID,
   output logic             REQ_ACCEPT,
   // Decoded settings
   output logic             CFG_VALID,
   output logic             AUTO_ASSIGNED_IP_SELECT,
   output logic             FIXED_IP_SELECT,
   output logic             LINK_TCP,
   output logic             LINK_RTU,
   output logic             COMM_ENABLE,
   output logic [7:0]       UNIT_ID,
   output logic [31:0]      IP_ADDR,
   output logic             IP_ADDR_VALID,
   // Wishbone classic slave
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic [31:0]      WB_DAT_O,
   output logic             WB_ACK_O
);
   logic        rst_meta;
   logic        rst_n;
   logic [9:0]  sw_sync;
   logic [15:0] settle_cnt;
   logic        latched;
   logic        dyn_sw;
   logic        eth_sw;
   logic [7:0]  addr_sw;
   logic [31:0] ip_store;
   csc_link_t   link;
   logic        use_dyn;
   logic        addr_ok;
   logic        comm_en;
   logic [7:0]  octet4;
   logic [31:0] next_ip;
   logic        wb_req;
   logic [31:0] next_dat;
   logic        ack_q;

   // True for a station address in the usable range
   function automatic logic addr_in_range(input logic [7:0] a);
      addr_in_range = (a >= CSC_ADDR_MIN) && (a <= CSC_ADDR_MAX);
   endfunction : addr_in_range

   // Byte-lane merge for a write to a 32-bit register
   function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                              input logic [31:0] dat,
                                              input logic [3:0]  sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++)
      begin
         if (sel[b])
            r[b*8 +: 8] = dat[b*8 +: 8];
      end
      lane_merge = r;
   endfunction : lane_merge

   // Reset release through two flip-flops
   always_ff @(posedge CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // Switch pins come from outside the clock domain
   csc_sync3 #(
      .W (10)
   ) u_sync (
      .clk   (CLK),
      .rst_n (rst_n),
      .d     ({SW_LINK_MODE, SW_IP_TYPE, SW_ADDR}),
      .q     (sw_sync)
   );

   // Settle counter: waits for the synchroniser and switch bounce before latching
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         settle_cnt <= '0;
      else if (!latched)
         settle_cnt <= settle_cnt + 16'h0001;
   end

   // One-time latch; later switch moves are ignored until the next reset
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         latched <= 1'b0;
         dyn_sw  <= CSC_DEF_DYN_SW;
         eth_sw  <= CSC_DEF_ETH_SW;
         addr_sw <= CSC_ADDR_ZERO;
      end
      else if (!latched && (settle_cnt >= 16'(SETTLE_CYC)))
      begin
         latched <= 1'b1;
         addr_sw <= sw_sync[7:0];
         dyn_sw  <= (sw_sync[8] == CSC_SW_ON);
         eth_sw  <= (sw_sync[9] == CSC_SW_ON);
      end
   end

   // Stored IP address, rewritable by the browser-side software
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
         ip_store <= CSC_IP_DEFAULT;
      else if (wb_req && WB_WE_I && !ack_q && (WB_ADR_I == CSC_REG_IP_STORE))
         ip_store <= lane_merge(ip_store, WB_DAT_I, WB_SEL_I);
   end

   // Mode decode from latched switches
   always_comb
   begin
      link    = eth_sw ? CSC_LINK_TCP : CSC_LINK_RTU;
      use_dyn = (link == CSC_LINK_TCP) && dyn_sw;
      // Zero is only usable in Ethernet mode, where the stored octet replaces it
      if (addr_sw == CSC_ADDR_OFF)
         addr_ok = 1'b0;
      else if (link == CSC_LINK_RTU)
         addr_ok = addr_in_range(addr_sw);
      else
         addr_ok = 1'b1;
      comm_en = latched && addr_ok;
   end

   // Fourth octet: switch value, or stored octet when the switches read zero
   always_comb
   begin
      if (addr_sw == CSC_ADDR_ZERO)
         octet4 = ip_store[7:0];
      else
         octet4 = addr_sw;
      next_ip = {ip_store[31:8], octet4};
   end

   // Decoded outputs are registered
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         CFG_VALID               <= 1'b0;
         AUTO_ASSIGNED_IP_SELECT <= 1'b0;
         FIXED_IP_SELECT         <= 1'b0;
         LINK_TCP                <= 1'b0;
         LINK_RTU                <= 1'b0;
         COMM_ENABLE             <= 1'b0;
         UNIT_ID                 <= CSC_ADDR_ZERO;
         IP_ADDR                 <= '0;
         IP_ADDR_VALID           <= 1'b0;
      end
      else
      begin
         CFG_VALID               <= latched;
         AUTO_ASSIGNED_IP_SELECT <= latched && use_dyn;
         FIXED_IP_SELECT         <= latched && (link == CSC_LINK_TCP) && !dyn_sw;
         LINK_TCP                <= latched && (link == CSC_LINK_TCP);
         LINK_RTU                <= latched && (link == CSC_LINK_RTU);
         COMM_ENABLE             <= comm_en;
         UNIT_ID                 <= addr_sw;
         // Automatic addressing leaves the IP to the external assignment
         IP_ADDR                 <= use_dyn ? 32'h00000000 : next_ip;
         IP_ADDR_VALID           <= comm_en && (link == CSC_LINK_TCP) && !use_dyn;
      end
   end

   // Unit identifier match; mismatch or disabled unit gets no response
   always_comb
   begin
      REQ_ACCEPT = REQ_VALID && COMM_ENABLE && (REQ_UNIT_ID == UNIT_ID);
   end

   // Wishbone read mux; unmapped addresses read as zero and are still acknowledged
   always_comb
   begin
      wb_req = WB_CYC_I && WB_STB_I;
      unique case (WB_ADR_I)
         CSC_REG_STATUS:
            next_dat = {16'h0000, UNIT_ID, 4'h0, COMM_ENABLE, AUTO_ASSIGNED_IP_SELECT,
                        LINK_TCP, CFG_VALID};
         CSC_REG_IP_STORE:
            next_dat = ip_store;
         CSC_REG_IP_USED:
            next_dat = IP_ADDR;
         CSC_REG_SWITCHES:
            next_dat = {22'h000000, sw_sync};
         default:
            next_dat = 32'h00000000;
      endcase
   end

   // One-wait-state acknowledge, dropped the cycle after it is given
   always_ff @(posedge CLK or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ack_q    <= 1'b0;
         WB_DAT_O <= '0;
      end
      else
      begin
         ack_q    <= wb_req && !ack_q;
         WB_DAT_O <= next_dat;
      end
   end

   assign WB_ACK_O = ack_q;
endmodule : csc_decoder

// ---- verilog/csc_pkg.sv ----
// Package of constants and types for the switch configuration decoder
package csc_pkg;
   // Switch and address widths
   localparam int          CSC_ADDR_W       = 8;
   // Switch sense: a closed (ON) switch reads as one
   localparam logic        CSC_SW_ON        = 1'b1;
   // Special station addresses
   localparam logic [7:0]  CSC_ADDR_ZERO    = 8'h00;
   localparam logic [7:0]  CSC_ADDR_MIN     = 8'h01;
   localparam logic [7:0]  CSC_ADDR_MAX     = 8'hfe;
   localparam logic [7:0]  CSC_ADDR_OFF     = 8'hff;
   // Factory stored IPv4 address, 192.168.100.1
   localparam logic [31:0] CSC_IP_DEFAULT   = 32'hc0a86401;
   // Factory switch positions: static addressing, Ethernet link
   localparam logic        CSC_DEF_DYN_SW   = 1'b0;
   localparam logic        CSC_DEF_ETH_SW   = 1'b1;
   // Settle time after reset release before the switches are latched
   localparam int          CSC_SETTLE_NS    = 1000;
   localparam int          CSC_CLK_NS       = 25;
   localparam int          CSC_SETTLE_CYC   = (CSC_SETTLE_NS + CSC_CLK_NS - 1) / CSC_CLK_NS;
   // Wishbone register offsets (byte addresses)
   localparam logic [7:0]  CSC_REG_STATUS   = 8'h00;
   localparam logic [7:0]  CSC_REG_IP_STORE = 8'h04;
   localparam logic [7:0]  CSC_REG_IP_USED  = 8'h08;
   localparam logic [7:0]  CSC_REG_SWITCHES = 8'h0c;
   // Status register field positions
   localparam int          CSC_ST_LATCHED   = 0;
   localparam int          CSC_ST_ETH       = 1;
   localparam int          CSC_ST_DYN       = 2;
   localparam int          CSC_ST_ENABLED   = 3;
   localparam int          CSC_ST_ID_LO     = 8;
   // Link modes
   typedef enum logic {CSC_LINK_RTU, CSC_LINK_TCP} csc_link_t;
endpackage : csc_pkg

// ---- verilog/csc_sync3.sv ----
// Three-stage input synchroniser with second/third agreement filter
module csc_sync3
   import csc_pkg::*;
#(
   parameter int W = 10
)
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst_n,
   // Raw and filtered levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] s1;
   logic [W-1:0] s2;
   logic [W-1:0] s3;

   // First stage is read only by the second
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         s1 <= '0;
         s2 <= '0;
         s3 <= '0;
      end
      else
      begin
         s1 <= d;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // A change counts once stages two and three agree, filtering one-cycle glitches
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         always_ff @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
               q[i] <= 1'b0;
            else if (s2[i] == s3[i])
               q[i] <= s3[i];
         end
      end
   endgenerate
endmodule : csc_sync3
